// File: hw/sar_adc_sequencer.sv
// Successive-approximation converter sequencer top level
`timescale 1ns/1ps
`include "sar_adc_consts.svh"
module sar_adc_sequencer (
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic RESET,
	// Host instruction strobes, one cycle each
	input wire logic FLAG_CLEAR_INSTRUCTION,
	input wire logic CONTROL_SET_INSTRUCTION,
	input wire logic SKIP_IF_FLAG_SET,
	input wire logic SKIP_IF_FLAG_CLEAR,
	input wire logic INPUT_INSTRUCTION,
	// Host internal clock pulse, asynchronous
	input wire logic HOST_CLK_PULSE,
	// Analog comparator, high when input is at or above the ladder
	input wire logic COMPARATOR_HIGH,
	// Ladder switch code, offset binary
	output logic [9:0] LADDER_CODE,
	// Status and data back to the host
	output logic FLAG_CHECK,
	output logic INTERRUPT_REQUEST,
	output logic SKIP_NEXT,
	output logic [15:0] INPUT_BUS
);
	import sar_adc_pkg::*;

	sar_step_if link ();

	sar_step_sync u_sync (
		.clk(SYS_CLK),
		.reset(RESET),
		.host_clk_pulse(HOST_CLK_PULSE),
		.cmp_high(COMPARATOR_HIGH),
		.link(link)
	);

	seq_regs_t r_ff;
	seq_regs_t nxt_r;
	logic completing;
	logic start_ok;
	logic [9:0] kept;
	logic [9:0] twos;
	logic [15:0] word;

	// Offset binary from the ladder becomes two's complement by flipping
	// the top bit; the word then copies the sign upward.
	assign twos = {~r_ff.result[`SIGN_BIT], r_ff.result[8:0]};
	assign word = {{6{twos[`SIGN_BIT]}}, twos};

	assign completing = (r_ff.state == ST_CONVERT) && link.step &&
		(r_ff.step == `LAST_STEP);
	// The completing pulse wins over a start in the same cycle, so the
	// flag set is never lost; the host must reissue the start.
	assign start_ok = FLAG_CLEAR_INSTRUCTION && !completing;
	assign kept = link.verdict ? r_ff.trial : (r_ff.trial & ~r_ff.mask);

	always_comb begin
		nxt_r = r_ff;
		nxt_r.skip = (SKIP_IF_FLAG_SET && r_ff.flag) ||
			(SKIP_IF_FLAG_CLEAR && !r_ff.flag);
		nxt_r.in_bus = INPUT_INSTRUCTION ? word : `WORD_RESET;
		if (CONTROL_SET_INSTRUCTION) begin
			nxt_r.control = 1'b1;
		end
		unique case (r_ff.state)
			ST_IDLE, ST_DONE: begin
				// Result and flag stand until the next start
				nxt_r.state = r_ff.state;
			end
			ST_CONVERT: begin
				if (link.step) begin
					nxt_r.step = r_ff.step + 4'h1;
					if (r_ff.step == `STEP_RESET) begin
						nxt_r.mask = `FIRST_TRIAL;
						nxt_r.trial = `FIRST_TRIAL;
					end else begin
						nxt_r.mask = r_ff.mask >> 1;
						nxt_r.trial = kept | (r_ff.mask >> 1);
					end
				end
				if (completing) begin
					nxt_r.result = kept;
					nxt_r.flag = 1'b1;
					nxt_r.irq = r_ff.control;
					nxt_r.state = ST_DONE;
				end
			end
		endcase
		if (start_ok) begin
			nxt_r.state = ST_CONVERT;
			nxt_r.step = `STEP_RESET;
			nxt_r.mask = `RESULT_RESET;
			nxt_r.trial = `RESULT_RESET;
			nxt_r.result = `RESULT_RESET;
			nxt_r.flag = 1'b0;
			nxt_r.irq = 1'b0;
		end
		if (RESET) begin
			nxt_r = '0;
			nxt_r.state = ST_IDLE;
		end
	end

	always_ff @(posedge SYS_CLK) begin
		r_ff <= nxt_r;
	end

	assign LADDER_CODE = r_ff.trial;
	assign FLAG_CHECK = r_ff.flag;
	assign INTERRUPT_REQUEST = r_ff.irq;
	assign SKIP_NEXT = r_ff.skip;
	assign INPUT_BUS = r_ff.in_bus;

	// Check-only counters: host steps taken and cycles spent converting
	logic [3:0] pulses_ff;
	logic [3:0] nxt_pulses;
	logic [8:0] cycles_ff;
	logic [8:0] nxt_cycles;
	always_comb begin
		nxt_pulses = pulses_ff;
		nxt_cycles = cycles_ff;
		if (link.step && r_ff.state == ST_CONVERT) begin
			nxt_pulses = pulses_ff + 4'h1;
		end
		// Saturate so a stalled host cannot wrap the count
		if (r_ff.state == ST_CONVERT && cycles_ff != 9'h1FF) begin
			nxt_cycles = cycles_ff + 9'h001;
		end
		if (RESET || start_ok) begin
			nxt_pulses = 4'h0;
			nxt_cycles = 9'h000;
		end
	end
	always_ff @(posedge SYS_CLK) begin
		pulses_ff <= nxt_pulses;
		cycles_ff <= nxt_cycles;
	end

	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RESET);

	start_clears_a: assert property (start_ok |=>
		LADDER_CODE == 10'h000 && !FLAG_CHECK && !INTERRUPT_REQUEST)
		else $error("start did not clear conversion state");
	first_trial_a: assert property (
		r_ff.state == ST_CONVERT && link.step && r_ff.step == 4'h0 &&
		!FLAG_CLEAR_INSTRUCTION |=> LADDER_CODE == 10'h200)
		else $error("first trial bit not set");
	reject_bit_a: assert property (
		r_ff.state == ST_CONVERT && link.step && r_ff.step != 4'h0 &&
		!link.verdict && !start_ok |=> (r_ff.trial & $past(r_ff.mask)) == 0)
		else $error("rejected trial bit kept");
	eleventh_pulse_a: assert property (
		$rose(FLAG_CHECK) |-> pulses_ff == 4'hB)
		else $error("flag not on the eleventh pulse");
	no_early_flag_a: assert property (
		r_ff.state == ST_CONVERT |-> !FLAG_CHECK)
		else $error("flag set during conversion");
	irq_gated_a: assert property (
		$rose(INTERRUPT_REQUEST) |-> $past(r_ff.control) && $rose(FLAG_CHECK))
		else $error("interrupt without control or completion");
	read_word_a: assert property (
		INPUT_INSTRUCTION && r_ff.state == ST_DONE && !start_ok
		|=> INPUT_BUS == $past(word))
		else $error("input bus does not carry result");
	sign_ext_a: assert property (
		INPUT_BUS[15:10] == {6{INPUT_BUS[9]}})
		else $error("sign not extended");
	full_scale_a: assert property (
		r_ff.result == 10'h3FF |-> word == 16'h01FF)
		else $error("positive full scale code wrong");
	hold_a: assert property (
		r_ff.state == ST_DONE && !start_ok |=> $stable(r_ff.result) &&
		FLAG_CHECK)
		else $error("result or flag changed before restart");
	skip_a: assert property (
		SKIP_IF_FLAG_SET && FLAG_CHECK |=> SKIP_NEXT)
		else $error("skip on set flag missed");
	skip_clear_a: assert property (
		SKIP_IF_FLAG_CLEAR && !FLAG_CHECK |=> SKIP_NEXT)
		else $error("skip on clear flag missed");
	skip_quiet_a: assert property (
		!(SKIP_IF_FLAG_SET && FLAG_CHECK) &&
		!(SKIP_IF_FLAG_CLEAR && !FLAG_CHECK) |=> !SKIP_NEXT)
		else $error("skip raised without a matching test");
	bus_idle_a: assert property (
		!INPUT_INSTRUCTION |=> INPUT_BUS == 16'h0000)
		else $error("input bus driven without a read");
	ladder_hold_a: assert property (
		r_ff.state == ST_CONVERT && !link.step && !start_ok |=>
		$stable(LADDER_CODE)) else $error("ladder moved without a step");
	step_bound_a: assert property (
		r_ff.state == ST_CONVERT |-> r_ff.step <= `LAST_STEP)
		else $error("step count ran past completion");
	irq_off_a: assert property (
		completing && !r_ff.control |=> !INTERRUPT_REQUEST)
		else $error("interrupt raised with control clear");
	irq_on_a: assert property (
		completing && r_ff.control |=> INTERRUPT_REQUEST)
		else $error("interrupt missing with control set");
	control_sticky_a: assert property (
		r_ff.control |=> r_ff.control)
		else $error("control dropped without reset");
	flag_done_a: assert property (
		FLAG_CHECK |-> r_ff.state == ST_DONE)
		else $error("flag set outside the done state");
	idle_quiet_a: assert property (
		r_ff.state == ST_IDLE |-> LADDER_CODE == 10'h000 && !FLAG_CHECK)
		else $error("idle converter shows state");
	ladder_done_a: assert property (
		r_ff.state == ST_DONE |-> LADDER_CODE == r_ff.result)
		else $error("ladder differs from held result");

	// Reset is checked with its own disable: the default one would hide
	// exactly the cycles under test
	reset_outputs_a: assert property (
		@(posedge SYS_CLK) disable iff (1'b0)
		RESET |=> LADDER_CODE == 10'h000 && !FLAG_CHECK &&
		!INTERRUPT_REQUEST && !SKIP_NEXT && !r_ff.control &&
		INPUT_BUS == 16'h0000)
		else $error("reset left an output set");

	conv_polled_c: cover property ($rose(FLAG_CHECK) && !INTERRUPT_REQUEST);
	conv_irq_c: cover property ($rose(INTERRUPT_REQUEST));
	conv_slow_c: cover property (
		$rose(FLAG_CHECK) && cycles_ff >= 9'(`CONV_CYCLES_SLOW));
	neg_full_c: cover property (FLAG_CHECK && word == 16'hFE00);
	restart_c: cover property (start_ok && r_ff.state == ST_CONVERT);
endmodule // sar_adc_sequencer

// File: hw/sar_adc_consts.svh
// Constants for the successive-approximation converter sequencer
`ifndef SAR_ADC_CONSTS_SVH
`define SAR_ADC_CONSTS_SVH

`define ADC_BITS 10
`define WORD_BITS 16
`define SIGN_BIT 9
`define RESULT_RESET 10'h000
`define WORD_RESET 16'h0000
`define FIRST_TRIAL 10'h200
`define LAST_STEP 4'hA
`define STEP_RESET 4'h0
`define SYS_CLK_PERIOD_NS 100
`define CONV_TIME_FAST_NS 17600
`define CONV_TIME_SLOW_NS 22000
`define CONV_CYCLES_FAST (`CONV_TIME_FAST_NS / `SYS_CLK_PERIOD_NS)
`define CONV_CYCLES_SLOW (`CONV_TIME_SLOW_NS / `SYS_CLK_PERIOD_NS)

`endif

// File: hw/sar_adc_pkg.sv
// Types shared by the converter sequencer modules
package sar_adc_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_CONVERT = 3'h2,
		ST_DONE = 3'h4
	} seq_state_t;

	typedef struct packed {
		seq_state_t state;
		logic [3:0] step;
		logic [9:0] mask;
		logic [9:0] trial;
		logic [9:0] result;
		logic flag;
		logic control;
		logic irq;
		logic skip;
		logic [15:0] in_bus;
	} seq_regs_t;

	typedef struct packed {
		logic clk_meta;
		logic clk_sync;
		logic clk_prev;
		logic cmp_meta;
		logic cmp_sync;
	} sync_regs_t;
endpackage

// File: hw/sar_step_if.sv
// Carrier for the synchronised host clock step and comparator verdict
`timescale 1ns/1ps
interface sar_step_if;
	logic step;
	logic verdict;
	modport sync (output step, output verdict);
	modport seq (input step, input verdict);
endinterface

// File: hw/sar_step_sync.sv
// Synchroniser for the host clock pulse and the comparator output
`timescale 1ns/1ps
module sar_step_sync (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Raw inputs from outside the clock domain
	input wire logic host_clk_pulse,
	input wire logic cmp_high,
	// Synchronised step and verdict
	sar_step_if.sync link
);
	import sar_adc_pkg::*;

	sync_regs_t r_ff;
	sync_regs_t nxt_r;

	always_comb begin
		nxt_r = r_ff;
		nxt_r.clk_meta = host_clk_pulse;
		nxt_r.clk_sync = r_ff.clk_meta;
		nxt_r.clk_prev = r_ff.clk_sync;
		nxt_r.cmp_meta = cmp_high;
		nxt_r.cmp_sync = r_ff.cmp_meta;
		if (reset) begin
			nxt_r = '0;
		end
	end

	always_ff @(posedge clk) begin
		r_ff <= nxt_r;
	end

	// One step per rising edge of the host clock pulse
	assign link.step = r_ff.clk_sync & ~r_ff.clk_prev;
	assign link.verdict = r_ff.cmp_sync;

	step_one_cycle_a: assert property (@(posedge clk) disable iff (reset)
		link.step |=> !link.step) else $error("step lasted two cycles");
endmodule // sar_step_sync

// File: sim/adc_analog_model.sv
// Comparator and ladder model standing in for the analog front end
`timescale 1ns/1ps
module adc_analog_model (
	// Trial code from the sequencer
	input wire logic [9:0] ladder,
	// Held analog input as an offset-binary code
	input wire logic [9:0] level,
	// Verdict back to the sequencer
	output logic cmp_high
);
	// Ideal comparator settles at once, so sync margins are never at risk
	assign cmp_high = (level >= ladder);
endmodule // adc_analog_model

// File: sim/tb.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
module tb;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic [4:0] ins = 5'h00;
	logic host_clk = 1'b0;
	logic [9:0] level = 10'h000;
	logic cmp_high;
	logic [9:0] ladder;
	logic flag, irq, skip;
	logic [15:0] in_bus;
	logic skip_s;
	logic [15:0] bus_s;
	int err_total = 0;
	int tests_run = 0;

	always #50 sys_clk = ~sys_clk;

	sar_adc_sequencer u_dut (
		.SYS_CLK(sys_clk),
		.RESET(reset),
		.FLAG_CLEAR_INSTRUCTION(ins[4]),
		.CONTROL_SET_INSTRUCTION(ins[3]),
		.SKIP_IF_FLAG_SET(ins[2]),
		.SKIP_IF_FLAG_CLEAR(ins[1]),
		.INPUT_INSTRUCTION(ins[0]),
		.HOST_CLK_PULSE(host_clk),
		.COMPARATOR_HIGH(cmp_high),
		.LADDER_CODE(ladder),
		.FLAG_CHECK(flag),
		.INTERRUPT_REQUEST(irq),
		.SKIP_NEXT(skip),
		.INPUT_BUS(in_bus)
	);

	adc_analog_model u_model (
		.ladder(ladder),
		.level(level),
		.cmp_high(cmp_high)
	);

	task check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One-cycle strobe; answers are caught in the cycle they stand
	task cmd(input logic [4:0] m);
		@(negedge sys_clk);
		ins = m;
		@(negedge sys_clk);
		skip_s = skip;
		bus_s = in_bus;
		ins = 5'h00;
	endtask

	// Host pulses 6 cycles high and low, wide enough for the synchroniser
	task steps(input int n);
		repeat (n) begin
			@(negedge sys_clk);
			host_clk = 1'b1;
			repeat (6) @(negedge sys_clk);
			host_clk = 1'b0;
			repeat (5) @(negedge sys_clk);
		end
	endtask

	// Slow host: 24-cycle pulse period, longer than the slow model's
	task slow_steps(input int n);
		repeat (n) begin
			@(negedge sys_clk);
			host_clk = 1'b1;
			repeat (12) @(negedge sys_clk);
			host_clk = 1'b0;
			repeat (11) @(negedge sys_clk);
		end
	endtask

	task conv_poll(input logic [9:0] lv, input logic [15:0] exp);
		level = lv;
		cmd(5'h10);
		check({irq, flag, 4'h0, ladder}, 16'h0000);
		steps(1);
		check({6'h00, ladder}, 16'h0200);
		steps(9);
		check({14'h0000, irq, flag}, 16'h0000);
		steps(1);
		check({14'h0000, irq, flag}, 16'h0001);
		cmd(5'h04);
		check({15'h0000, skip_s}, 16'h0001);
		cmd(5'h02);
		check({15'h0000, skip_s}, 16'h0000);
		cmd(5'h01);
		check(bus_s, exp);
		steps(1);
		cmd(5'h01);
		check(bus_s, exp);
		check({14'h0000, irq, flag}, 16'h0001);
		@(negedge sys_clk);
		check(in_bus, 16'h0000);
	endtask

	task conv_restart;
		level = 10'h155;
		cmd(5'h10);
		steps(5);
		cmd(5'h02);
		check({15'h0000, skip_s}, 16'h0001);
		cmd(5'h04);
		check({15'h0000, skip_s}, 16'h0000);
		cmd(5'h10);
		check({6'h00, ladder}, 16'h0000);
		steps(10);
		check({14'h0000, irq, flag}, 16'h0000);
		steps(1);
		check({14'h0000, irq, flag}, 16'h0001);
		cmd(5'h01);
		check(bus_s, 16'hFF55);
	endtask

	task conv_irq;
		level = 10'h3FF;
		cmd(5'h18);
		steps(10);
		check({14'h0000, irq, flag}, 16'h0000);
		steps(1);
		check({14'h0000, irq, flag}, 16'h0003);
		cmd(5'h01);
		check(bus_s, 16'h01FF);
		cmd(5'h10);
		check({14'h0000, irq, flag}, 16'h0000);
	endtask

	// Reset in mid-conversion clears control too; then a slow host shows
	// that the conversion length follows the host pulses alone
	task reset_mid;
		level = 10'h200;
		cmd(5'h10);
		steps(4);
		@(negedge sys_clk);
		reset = 1'b1;
		repeat (3) @(negedge sys_clk);
		reset = 1'b0;
		check({irq, flag, skip, 3'h0, ladder}, 16'h0000);
		check(in_bus, 16'h0000);
		cmd(5'h10);
		slow_steps(10);
		check({14'h0000, irq, flag}, 16'h0000);
		slow_steps(1);
		check({14'h0000, irq, flag}, 16'h0001);
		cmd(5'h01);
		check(bus_s, 16'h0000);
	endtask

	task results;
		$display("Comparisons %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (16) @(negedge sys_clk);
		reset = 1'b0;
		conv_poll(10'h3FF, 16'h01FF);
		conv_poll(10'h200, 16'h0000);
		conv_poll(10'h000, 16'hFE00);
		conv_poll(10'h155, 16'hFF55);
		conv_restart;
		conv_irq;
		reset_mid;
		results;
	end

	// About fifteen times the expected run length
	initial begin
		#(20000 * 100);
		err_total++;
		results;
	end
endmodule // tb
